/* scd_defines.vh */
// constants for the sensor configuration decoder
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register port
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH
`define SCD_CLK_HZ 50000000
`define SCD_RATE0_HZ 1600
`define SCD_RATE1_HZ 800
`define SCD_RATE2_HZ 400
`define SCD_RATE3_HZ 200
// register byte offsets
`define SCD_A_IMG_LAST 8'h3C
`define SCD_A_CTRL 8'h40
`define SCD_A_STAT 8'h44
`define SCD_A_PT1 8'h48
`define SCD_A_PT2 8'h4C
`define SCD_A_PT3 8'h50
`define SCD_A_PT4 8'h54
`define SCD_A_PT5 8'h58
`define SCD_A_CLAMP 8'h5C
// image reset values
`define SCD_W1_RST 16'h0008
`define SCD_W9_RST 16'h8000
`define SCD_W10_RST 16'h0001
`define SCD_W11_RST 16'h03FF
// crc
`define SCD_CRC_POLY 20'h00013
`define SCD_W2_MASK 16'h0FFF
// image word indices and the lock bit index
`define SCD_W_CRC 2
`define SCD_W_LOCK 14
`define SCD_LOCK_BIT 10
// axi responses
`define SCD_RESP_OK 2'h0
`define SCD_RESP_SLVERR 2'h2
`define SCD_RESP_DECERR 2'h3
// output select codes
`define SCD_OUT_PWM 2'h2
`define SCD_OUT_ANALOG 2'h3
`endif

/* scd_top.v */
// sensor configuration image decoder with position output path
// assumes AXI4-Lite master on i_sys_clk; pins are asynchronous
`timescale 1ns/1ps
`include "scd_defines.vh"
module scd_top #(
    parameter P_RATE0_CYC = `SCD_CLK_HZ / `SCD_RATE0_HZ,
    parameter P_RATE1_CYC = `SCD_CLK_HZ / `SCD_RATE1_HZ,
    parameter P_RATE2_CYC = `SCD_CLK_HZ / `SCD_RATE2_HZ,
    parameter P_RATE3_CYC = `SCD_CLK_HZ / `SCD_RATE3_HZ
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire [7:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [7:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    input wire i_nv_write_enable_pin,
    input wire i_osc_fault,
    input wire [11:0] i_coil_input_a,
    input wire [11:0] i_coil_input_b,
    input wire [12:0] i_position,
    output reg [11:0] o_sine,
    output reg [11:0] o_cosine,
    output reg o_fir_enable,
    output reg [1:0] o_osc_tail_current_sel,
    output reg o_feedback_radius_sel,
    output reg o_gain_polarity,
    output reg [1:0] o_gain_steps,
    output reg [9:0] o_osc_amplitude_comp,
    output reg [12:0] o_origin_offset,
    output reg [11:0] o_first_segment_slope,
    output reg [11:0] o_last_segment_slope,
    output reg o_adc_clk,
    output reg o_pwm_pp,
    output reg o_aout_analog_en,
    output reg [12:0] o_analog_code,
    output reg o_open_drain_pulse_output,
    output reg o_open_drain_pulse_oe_n
);

    function [3:0] scd_crc4;
        input [19:0] b;
        reg [19:0] r;
        integer i;
        begin
            r = b;
            for (i = 19; i >= 4; i = i - 1) begin
                if (r[i])
                    r = r ^ (`SCD_CRC_POLY << (i - 4));
            end
            scd_crc4 = r[3:0];
        end
    endfunction

    function [13:0] scd_x2;
        input [12:0] v;
        begin
            scd_x2 = {v, 1'b0};
        end
    endfunction

    reg [15:0] img [0:15];
    reg [1:0] we_sync;
    reg [1:0] flt_sync;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg chk_req;
    reg crc_err;
    reg crc_done;
    reg [3:0] crc_calc;
    reg [17:0] pwm_cnt;
    reg [5:0] div_cnt;
    reg [12:0] pos_clamped;
    integer k;
    integer j;

    wire [1:0] refresh = img[1][13:12];
    wire [3:0] out_sel = img[3][15:12];
    wire nv_write_protect = img[`SCD_W_LOCK][`SCD_LOCK_BIT];
    wire wr_locked = nv_write_protect & ~we_sync[1];

    // image sum and crc
    reg [19:0] sum;
    always @* begin
        sum = 20'h00000;
        for (k = 0; k < 16; k = k + 1) begin
            if (k == `SCD_W_CRC)
                sum = sum + {4'h0, img[k] & `SCD_W2_MASK};
            else
                sum = sum + {4'h0, img[k]};
        end
    end
    wire [15:0] fold = sum[19:16] ^ sum[15:0];
    wire [3:0] crc_now = scd_crc4({fold, 4'h0});

    // derived linearisation points
    wire [12:0] x1 = {1'b0, img[9][11:0]};
    wire [12:0] y1 = {1'b0, img[8][11:0]};
    wire [12:0] x3 = {1'b0, img[7][11:0]};
    wire [12:0] y3 = {1'b0, img[6][11:0]};
    wire [12:0] x5 = {1'b0, img[5][11:0]};
    wire [12:0] y5 = {1'b0, img[4][11:0]};
    // the mean of two points, doubled internally, is their sum; y2s and y4s also add a signed offset doubled from word 12 or 13
    wire [13:0] x2s = {1'b0, x1} + {1'b0, x3};
    wire [13:0] x4s = {1'b0, x3} + {1'b0, x5};
    wire [13:0] y2s = {1'b0, y1} + {1'b0, y3} + {{7{img[12][15]}}, img[12][15:10], 1'b0};
    wire [13:0] y4s = {1'b0, y3} + {1'b0, y5} + {{7{img[13][15]}}, img[13][15:10], 1'b0};

    // clamps: high 8*(v+1)-1, low 8*(v-1) floored at zero
    wire [12:0] hi_clamp = {img[11][9:0], 3'h7};
    wire [12:0] lo_clamp = (img[10][9:0] == 10'h000) ? 13'h0000 :
        {img[10][9:0] - 10'h001, 3'h0};

    reg [17:0] period;
    always @* begin
        case (refresh)
            2'h0: period = P_RATE0_CYC[17:0];
            2'h1: period = P_RATE1_CYC[17:0];
            2'h2: period = P_RATE2_CYC[17:0];
            default: period = P_RATE3_CYC[17:0];
        endcase
    end
    wire [30:0] duty_full = {13'h0000, period} * {18'h00000, pos_clamped};
    wire [17:0] duty = duty_full[30:13];

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            we_sync <= 2'h0;
            flt_sync <= 2'h0;
        end else begin
            we_sync <= {we_sync[0], i_nv_write_enable_pin};
            flt_sync <= {flt_sync[0], i_osc_fault};
        end
    end

    // axi write side
    wire wr_go = aw_held & w_held & ~o_s_axi_bvalid;
    wire wr_img = (aw_addr <= `SCD_A_IMG_LAST);
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            for (j = 0; j < 16; j = j + 1)
                img[j] <= 16'h0000;
            img[1] <= `SCD_W1_RST;
            img[9] <= `SCD_W9_RST;
            img[10] <= `SCD_W10_RST;
            img[11] <= `SCD_W11_RST;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `SCD_RESP_OK;
            chk_req <= 1'b0;
        end else begin
            chk_req <= 1'b0;
            if (i_s_axi_awvalid & o_s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
                o_s_axi_awready <= 1'b0;
            end
            if (i_s_axi_wvalid & o_s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
                o_s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= `SCD_RESP_OK;
                if (aw_addr[1:0] != 2'h0) begin
                    o_s_axi_bresp <= `SCD_RESP_DECERR;
                end else if (wr_img) begin
                    if (wr_locked) begin
                        o_s_axi_bresp <= `SCD_RESP_SLVERR;
                    end else begin
                        if (w_strb[0])
                            img[aw_addr[5:2]][7:0] <= w_data[7:0];
                        if (w_strb[1])
                            img[aw_addr[5:2]][15:8] <= w_data[15:8];
                    end
                end else if (aw_addr == `SCD_A_CTRL) begin
                    chk_req <= w_strb[0] & w_data[0];
                end else if (aw_addr == `SCD_A_STAT) begin
                    o_s_axi_bresp <= `SCD_RESP_OK;
                end else begin
                    o_s_axi_bresp <= `SCD_RESP_DECERR;
                end
            end
            if (o_s_axi_bvalid & i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
        end
    end

    // crc check: set by a check request wins over a clear by status write
    wire err_clr = wr_go & (aw_addr == `SCD_A_STAT) & w_strb[0] & w_data[1];
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            crc_err <= 1'b0;
            crc_done <= 1'b0;
            crc_calc <= 4'h0;
        end else begin
            crc_calc <= crc_now;
            if (chk_req) begin
                crc_done <= 1'b1;
                crc_err <= (crc_now != img[`SCD_W_CRC][15:12]);
            end else if (err_clr) begin
                crc_err <= 1'b0;
            end
        end
    end

    // axi read side, answer one cycle after address taken
    reg [31:0] rd_mux;
    reg [1:0] rd_resp;
    always @* begin
        rd_mux = 32'h00000000;
        rd_resp = `SCD_RESP_OK;
        if (i_s_axi_araddr[1:0] != 2'h0)
            rd_resp = `SCD_RESP_DECERR;
        else if (i_s_axi_araddr <= `SCD_A_IMG_LAST)
            rd_mux = {16'h0000, img[i_s_axi_araddr[5:2]]};
        else begin
            case (i_s_axi_araddr)
                `SCD_A_CTRL: rd_mux = 32'h00000000;
                `SCD_A_STAT: rd_mux = {24'h000000, crc_calc, wr_locked, crc_done,
                    crc_err, 1'b0};
                `SCD_A_PT1: rd_mux = {2'h0, scd_x2(y1), 2'h0, scd_x2(x1)};
                `SCD_A_PT2: rd_mux = {2'h0, y2s, 2'h0, x2s};
                `SCD_A_PT3: rd_mux = {2'h0, scd_x2(y3), 2'h0, scd_x2(x3)};
                `SCD_A_PT4: rd_mux = {2'h0, y4s, 2'h0, x4s};
                `SCD_A_PT5: rd_mux = {2'h0, scd_x2(y5), 2'h0, scd_x2(x5)};
                `SCD_A_CLAMP: rd_mux = {3'h0, hi_clamp, 3'h0, lo_clamp};
                default: rd_resp = `SCD_RESP_DECERR;
            endcase
        end
    end
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `SCD_RESP_OK;
        end else if (i_s_axi_arvalid & o_s_axi_arready) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= rd_mux;
            o_s_axi_rresp <= rd_resp;
        end else if (o_s_axi_rvalid & i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_arready <= 1'b1;
        end
    end

    // decoded settings and signal path
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_sine <= 12'h000;
            o_cosine <= 12'h000;
            o_fir_enable <= 1'b0;
            o_osc_tail_current_sel <= 2'h0;
            o_feedback_radius_sel <= 1'b1;
            o_gain_polarity <= 1'b0;
            o_gain_steps <= 2'h0;
            o_osc_amplitude_comp <= 10'h000;
            o_origin_offset <= 13'h0000;
            o_first_segment_slope <= 12'h000;
            o_last_segment_slope <= 12'h000;
            pos_clamped <= 13'h0000;
        end else begin
            if (img[14][11]) begin
                o_sine <= i_coil_input_a;
                o_cosine <= i_coil_input_b;
            end else begin
                o_sine <= i_coil_input_b;
                o_cosine <= i_coil_input_a;
            end
            o_fir_enable <= img[9][15];
            o_osc_tail_current_sel <= img[14][15:14];
            o_feedback_radius_sel <= img[1][3];
            o_gain_polarity <= img[1][6];
            o_gain_steps <= img[1][5:4];
            o_osc_amplitude_comp <= {img[7][15:12], img[8][15:12], 2'h0};
            o_origin_offset <= {img[4][15:12], img[5][15:12], img[6][15:12], 1'b0};
            o_first_segment_slope <= img[3][11:0];
            o_last_segment_slope <= img[2][11:0];
            if (i_position < lo_clamp)
                pos_clamped <= lo_clamp;
            else if (i_position > hi_clamp)
                pos_clamped <= (lo_clamp > hi_clamp) ? lo_clamp : hi_clamp;
            else
                pos_clamped <= i_position;
        end
    end

    // pwm, converter clock and pin modes
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            pwm_cnt <= 18'h00000;
            div_cnt <= 6'h00;
            o_adc_clk <= 1'b0;
            o_pwm_pp <= 1'b0;
            o_aout_analog_en <= 1'b0;
            o_analog_code <= 13'h0000;
            o_open_drain_pulse_output <= 1'b0;
            o_open_drain_pulse_oe_n <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 6'h01;
            o_adc_clk <= div_cnt[{1'b0, refresh} + 3'h2];
            if (pwm_cnt >= period - 18'h00001)
                pwm_cnt <= 18'h00000;
            else
                pwm_cnt <= pwm_cnt + 18'h00001;
            o_pwm_pp <= (out_sel[1:0] == `SCD_OUT_PWM) & (pwm_cnt < duty);
            o_aout_analog_en <= (out_sel[1:0] == `SCD_OUT_ANALOG);
            if ((out_sel[1:0] == `SCD_OUT_ANALOG) & ~flt_sync[1])
                o_analog_code <= pos_clamped;
            else
                o_analog_code <= 13'h0000;
            o_open_drain_pulse_output <= 1'b0;
            o_open_drain_pulse_oe_n <= ~((out_sel[3:2] == `SCD_OUT_PWM) &
                ~(pwm_cnt < duty));
        end
    end

endmodule // scd_top

/* scd_top_monitor.sv */
// assertion checker for the configuration decoder bus and output path
// sees only scd_top ports; bound into every scd_top instance
`timescale 1ns/1ps
module scd_top_monitor (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_s_axi_awvalid,
    input wire o_s_axi_awready,
    input wire i_s_axi_wvalid,
    input wire o_s_axi_wready,
    input wire [1:0] o_s_axi_bresp,
    input wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire [31:0] o_s_axi_rdata,
    input wire o_s_axi_rvalid,
    input wire i_s_axi_rready,
    input wire i_osc_fault,
    input wire [11:0] i_coil_input_a,
    input wire [11:0] i_coil_input_b,
    input wire [11:0] o_sine,
    input wire [11:0] o_cosine,
    input wire o_aout_analog_en,
    input wire [12:0] o_analog_code
);
default clocking cb @(posedge i_sys_clk); endclocking
default disable iff (!i_rstn);
chk_b_delay: assert property ((i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
    && o_s_axi_wready) |-> ##2 o_s_axi_bvalid) else $error("write response late");
chk_r_delay: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
chk_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
    && $stable(o_s_axi_bresp)) else $error("write response dropped");
chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid
    && $stable(o_s_axi_rdata)) else $error("read data dropped");
chk_aw_refuse: assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready)
    else $error("second write accepted");
chk_route_swap:
assert property (i_rstn && i_coil_input_a != i_coil_input_b |=> (o_sine == $past(i_coil_input_a)
    || o_sine == $past(i_coil_input_b)) && ((o_sine == $past(i_coil_input_a))
    == (o_cosine == $past(i_coil_input_b)))) else $error("coil routing wrong");
chk_fault_zero:
assert property (i_osc_fault [*5] |-> o_analog_code == 13'h0000)
    else $error("analog output not zero on fault");
chk_analog_off:
assert property (!o_aout_analog_en [*4] |-> o_analog_code == 13'h0000)
    else $error("analog code outside analog mode");
cov_slverr: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
cov_analog: cover property (o_aout_analog_en && o_analog_code != 13'h0000);
cov_fault: cover property (i_osc_fault && o_aout_analog_en);
endmodule // scd_top_monitor

bind scd_top scd_top_monitor u_scd_top_monitor (.i_sys_clk, .i_rstn, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
    .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid,
    .i_s_axi_rready, .i_osc_fault, .i_coil_input_a, .i_coil_input_b, .o_sine, .o_cosine,
    .o_aout_analog_en, .o_analog_code);

/* scd_coil_model.sv */
// model of the coil front end and the raw position source
// assumes the position level is set by the bench on the system clock
`timescale 1ns/1ps
module scd_coil_model (
    input wire i_clk,
    input wire [12:0] i_pos,
    output wire [11:0] o_a,
    output wire [11:0] o_b,
    output wire [12:0] o_position
);
logic [11:0] cnt = 12'h000;
logic [12:0] pos = 13'h0000;
always @(posedge i_clk) begin
    cnt <= cnt + 12'h001;
    pos <= i_pos;
end
// the two channels always differ so a swap is visible
assign o_a = cnt;
assign o_b = ~cnt;
assign o_position = pos;
endmodule // scd_coil_model

/* testbench.sv */
// bench: bus read and write tasks with a scenario sequence and a verdict
// assumes scd_top and scd_coil_model in the same folder
`timescale 1ns/1ps
`include "scd_defines.vh"
module testbench;
logic i_sys_clk, i_rstn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
logic i_s_axi_rready, i_nv_write_enable_pin, i_osc_fault, o_s_axi_awready, o_s_axi_wready;
logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_fir_enable, o_feedback_radius_sel;
logic o_gain_polarity, o_adc_clk, o_pwm_pp, o_aout_analog_en, o_open_drain_pulse_output;
logic o_open_drain_pulse_oe_n;
logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_osc_tail_current_sel, o_gain_steps, r;
logic [3:0] i_s_axi_wstrb;
logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
logic [9:0] o_osc_amplitude_comp;
logic [11:0] i_coil_input_a, i_coil_input_b, o_sine, o_cosine;
logic [11:0] o_first_segment_slope, o_last_segment_slope;
logic [12:0] i_position, o_origin_offset, o_analog_code, pos;
logic [15:0] img [16];
logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d;
int num_errors, comparisons, n;
int pi [10] = '{4, 5, 6, 7, 8, 9, 12, 13, 3, 2};
logic [15:0] pv [10] = '{16'h1258, 16'h21F4, 16'h3190, 16'hF12C, 16'hF0C8, 16'h0064,
    16'hF400, 16'h1400, 16'h0ABC, 16'h0DEF};
int ex [5] = '{200, 400, 600, 800, 1000};
int ey [5] = '{400, 594, 800, 1010, 1200};
scd_top #(.P_RATE0_CYC(100), .P_RATE1_CYC(200), .P_RATE2_CYC(400), .P_RATE3_CYC(800))
    u_scd_top (.*);
scd_coil_model u_scd_coil_model (.i_clk(i_sys_clk), .i_pos(pos), .o_a(i_coil_input_a),
    .o_b(i_coil_input_b), .o_position(i_position));
initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
end
task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", nm, e, s);
    end
endtask
task automatic wr(input [7:0] a, input [31:0] v);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= v;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
        @(posedge i_sys_clk);
        if (!ad && o_s_axi_awready === 1'b1) begin
            ad = 1;
            i_s_axi_awvalid <= 1'b0;
        end
        if (!wd && o_s_axi_wready === 1'b1) begin
            wd = 1;
            i_s_axi_wvalid <= 1'b0;
        end
    end
    do @(posedge i_sys_clk); while (o_s_axi_bvalid !== 1'b1);
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
    // keep a shadow of the image so crc() and word 2 rewrites use exactly what was written
    if (a < 8'h40 && r === 2'h0) img[a[5:2]] = v[15:0];
endtask
task automatic rd(input [7:0] a);
    @(posedge i_sys_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do @(posedge i_sys_clk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    while (o_s_axi_rvalid !== 1'b1) @(posedge i_sys_clk);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
endtask
task automatic wi(input int i, input [15:0] v);
    wr(8'(i * 4), {16'h0000, v});
    repeat (2) @(posedge i_sys_clk);
endtask
// cycles between two rising edges of the pwm or the converter clock
task automatic per(input bit p);
    int k;
    bit v, o;
    k = 0;
    o = 1;
    n = 0;
    while (k < 3) begin
        @(posedge i_sys_clk);
        v = p ? o_pwm_pp : o_adc_clk;
        if (v && !o) k++;
        if (k == 2) n++;
        o = v;
    end
endtask
function automatic [3:0] crc();
    logic [31:0] s;
    logic [19:0] b;
    s = 0;
    for (int i = 0; i < 16; i++) s += (i == 2) ? (img[i] & 16'h0FFF) : img[i];
    b = {s[31:16] ^ s[15:0], 4'h0};
    for (int i = 19; i >= 4; i--) if (b[i]) b ^= 20'h00013 << (i - 4);
    return b[3:0];
endfunction
task automatic run_check(input [1:0] e);
    wr(`SCD_A_CTRL, 32'h0000_0001);
    repeat (2) @(posedge i_sys_clk);
    rd(`SCD_A_STAT);
    chk("crc value", d[7:4], crc());
    chk("crc status", d[2:1], e);
endtask
task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
initial begin
    repeat (40000) @(posedge i_sys_clk);
    num_errors++;
    test_done;
end
initial begin
    {i_rstn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_osc_fault} = 5'h00;
    {i_s_axi_arvalid, i_s_axi_rready, i_s_axi_awaddr, i_s_axi_araddr} = 18'h00000;
    i_s_axi_wdata = 32'h0;
    i_s_axi_wstrb = 4'hF;
    i_nv_write_enable_pin = 1'b1;
    pos = 13'h0000;
    foreach (img[i]) img[i] = 16'h0000;
    img[1] = 16'h0008;
    img[9] = 16'h8000;
    img[10] = 16'h0001;
    img[11] = 16'h03FF;
    repeat (20) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
        rd(8'(i * 4));
        chk("image word", d, {16'h0000, img[i]});
    end
    chk("filter", o_fir_enable, 1);
    rd(`SCD_A_CLAMP);
    chk("clamps", d, 32'h1FFF_0000);
    wi(1, 16'h0F78);
    rd(8'h04);
    chk("word1", d, 32'h0F78);
    chk("gain", {o_gain_polarity, o_gain_steps}, 3'h7);
    wi(1, 16'h0F27);
    chk("gain", {o_gain_polarity, o_gain_steps, o_feedback_radius_sel}, 4'h4);
    wi(3, 16'h2000);
    pos <= 13'h1000;
    for (int c = 0; c < 4; c++) begin
        wi(1, 16'(16'h0008 + c * 16'h1000));
        per(0);
        chk("adc period", n, 8 << c);
        per(1);
        chk("pwm period", n, 100 << c);
    end
    wi(3, 16'h8000);
    n = 0;
    repeat (800) begin
        @(posedge i_sys_clk);
        if (o_open_drain_pulse_oe_n === 1'b0) n++;
    end
    chk("open drain low", n, 400);
    chk("open drain level", o_open_drain_pulse_output, 0);
    for (int c = 0; c < 4; c++) begin
        wi(14, 16'(c * 16'h4000 + (c % 2) * 16'h0800));
        chk("tail", o_osc_tail_current_sel, c);
        @(posedge i_sys_clk);
        d = i_coil_input_a;
        @(posedge i_sys_clk);
        chk("routed", (c % 2) ? o_sine : o_cosine, d);
    end
    for (int i = 0; i < 10; i++) wi(pi[i], pv[i]);
    chk("filter", o_fir_enable, 0);
    chk("amplitude", o_osc_amplitude_comp, 1020);
    chk("origin", o_origin_offset, 13'h0246);
    chk("slopes", {o_first_segment_slope, o_last_segment_slope}, 24'hABCDEF);
    for (int k = 0; k < 5; k++) begin
        rd(8'(`SCD_A_PT1 + 4 * k));
        chk("point", d, (ey[k] << 16) | ex[k]);
    end
    wi(3, 16'h3000);
    chk("analog enable", o_aout_analog_en, 1);
    chk("push-pull off", o_pwm_pp, 0);
    wi(11, 16'h00FF);
    wi(10, 16'h0005);
    pos <= 13'h1FFF;
    repeat (6) @(posedge i_sys_clk);
    chk("analog", o_analog_code, 2047);
    pos <= 13'h0000;
    repeat (6) @(posedge i_sys_clk);
    chk("analog", o_analog_code, 32);
    wi(10, 16'd200);
    wi(11, 16'd10);
    pos <= 13'd4000;
    repeat (6) @(posedge i_sys_clk);
    chk("analog", o_analog_code, 1592);
    rd(`SCD_A_CLAMP);
    chk("clamps", d, (87 << 16) | 1592);
    i_osc_fault <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    chk("analog", o_analog_code, 0);
    i_osc_fault <= 1'b0;
    wi(14, 16'h0400);
    i_nv_write_enable_pin <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    wr(8'h00, 32'h1234);
    chk("locked resp", r, `SCD_RESP_SLVERR);
    rd(8'h00);
    chk("word0", d, 32'h0);
    i_nv_write_enable_pin <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    wr(8'h00, 32'h1234);
    chk("open resp", r, `SCD_RESP_OK);
    rd(8'h60);
    chk("unmapped resp", r, `SCD_RESP_DECERR);
    chk("unmapped data", d, 32'h0);
    wr(8'h02, 32'h0);
    chk("unaligned write", r, `SCD_RESP_DECERR);
    wi(2, {crc() ^ 4'h1, img[2][11:0]});
    run_check(2'b11);
    wr(`SCD_A_STAT, 32'h0000_0002);
    wi(2, {crc(), img[2][11:0]});
    run_check(2'b10);
    test_done;
end
endmodule // testbench
